// ==== verilog/hdlc_rx_pkg.sv ====
// Package with register map, field positions, codes and carrier types of the receive HDLC FIFO block.
package hdlc_rx_pkg;
	// Register byte addresses on APB; odd offsets kept as indices, byte address is four times the index.
	localparam logic [11:0] IDX_IRQ_ENABLE = 12'h00A4;
	localparam logic [11:0] IDX_BYTES_COUNT = 12'h00B5;
	localparam logic [11:0] IDX_READ_PORT = 12'h00B6;
	localparam logic [11:0] IDX_WM_CTRL = 12'h0087;
	localparam logic [11:0] IDX_LIVE_STATUS = 12'h00C0;
	localparam logic [11:0] IDX_STICKY = 12'h00C1;
	localparam logic [11:0] IDX_RX_CTRL = 12'h0010;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Field positions.
	localparam int WM_SEL_LO = 0;
	localparam int SEG_FLAG_BIT = 7;
	localparam int LIVE_DATA_BIT = 0;
	localparam int LIVE_WM_BIT = 1;
	localparam int LIVE_PS_LO = 4;
	localparam int EV_FILLED = 0;
	localparam int EV_WM = 1;
	localparam int EV_START = 2;
	localparam int EV_END = 3;
	localparam int EV_FIRST = 4;
	localparam int EV_OVF = 5;
	localparam int SOFT_RESET_BIT = 6;
	// Watermark levels in bytes.
	localparam logic [6:0] WM_LEVEL0 = 7'h04;
	localparam logic [6:0] WM_LEVEL1 = 7'h10;
	localparam logic [6:0] WM_LEVEL2 = 7'h20;
	localparam logic [6:0] WM_LEVEL3 = 7'h30;
	// Packet state codes.
	typedef enum logic [2:0] {
		PS_IN_PROGRESS = 3'b000,
		PS_GOOD = 3'b001,
		PS_CRC_ERR = 3'b010,
		PS_ABORT = 3'b011,
		PS_OVERRUN = 3'b100
	} packet_state_code_t;
	// Byte as delivered by the deframer.
	typedef struct packed {
		logic [7:0] data;
		logic first;
	} rx_byte_t;
	// End of packet report from the deframer.
	typedef struct packed {
		logic valid;
		packet_state_code_t code;
	} rx_end_t;
endpackage

// ==== verilog/hdlc_rx_fifo_status.sv ====
// Receive HDLC FIFO, packet byte counting, status, masking and interrupt with an APB slave.
// Notes on behaviour
// - Selector picks watermark 4, 16, 32, 48.
// - Count gives bytes readable before message end.
// - Bit 7 set for start/continuation, else clear.
// - Data read returns next byte, LSB bit 0.
// - Latched bit holds until read, then clears.
// - Writing ones clears latched bits only.
// - Enabled latched events pull interrupt low.
// - Interrupt releases after reading causing bit.
// - Live bit 0 shows FIFO not empty.
// - Live bit 1 shows fill above watermark.
// - Live bits 4-6 give packet state code.
// - Seven ones abort ends packet, reports code.
// - Full FIFO stops packet, reports overrun.
// - Latched bit 0 on not-empty rising edge.
// - Latched bit 1 on watermark rising edge.
// - Latched bit 2 on packet opening byte.
// - Latched bit 3 on any packet end.
// - Latched bit 4 when first byte waits.
// - Mask bits 0-5 enable each event.
// - Soft reset bit flushes FIFO, edge triggered.
//
// Decided for this implementation: register access over APB.
module hdlc_rx_fifo_status
	import hdlc_rx_pkg::*;
#(
	parameter int DEPTH = 64 // FIFO depth in bytes.
) (
	input wire logic CLOCK_IN, // System clock, 40 MHz.
	input wire logic ARST_N_IN, // Asynchronous active-low reset.
	input wire logic PSEL_IN, // APB select.
	input wire logic PENABLE_IN, // APB enable.
	input wire logic PWRITE_IN, // APB direction, high for write.
	input wire logic [13:0] PADDR_IN, // APB byte address.
	input wire logic [31:0] PWDATA_IN, // APB write data.
	output logic [31:0] PRDATA_OUT, // APB read data.
	output logic PREADY_OUT, // APB ready.
	output logic PSLVERR_OUT, // APB error for unmapped address.
	input wire logic RX_BYTE_VALID_IN, // Deframer delivers a byte.
	input wire logic [7:0] RX_BYTE_DATA_IN, // Delivered byte.
	input wire logic RX_OPENING_IN, // Pulse: opening byte of a packet seen.
	input wire logic RX_END_VALID_IN, // Pulse: packet ended.
	input wire logic [2:0] RX_END_CODE_IN, // End code: good, CRC error or abort.
	output logic RX_OVERRUN_OUT, // Level: current packet dropped after overrun.
	output logic RX_SOFT_RESET_OUT, // Pulse: reset request to the deframer.
	output logic INT_N_OUT // Active-low interrupt.
);
	// The pointer arithmetic and the 7-bit byte count only serve a depth of 64.
	if (DEPTH != 64) begin
		$error("DEPTH must be 64");
	end

	localparam int AW = $clog2(DEPTH); // Pointer width.

	// Reset synchroniser.
	// Only the second flop's output is used as the reset of the rest of the block.
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Maps a watermark selector to its level.
	function automatic logic [6:0] wm_level(input logic [1:0] sel);
		case (sel)
			2'b00: wm_level = WM_LEVEL0;
			2'b01: wm_level = WM_LEVEL1;
			2'b10: wm_level = WM_LEVEL2;
			default: wm_level = WM_LEVEL3;
		endcase
	endfunction

	// Turns a register index into its APB byte address.
	function automatic logic [13:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	// Storage: data byte, first-of-message mark, end-of-message mark with its code.
	logic [7:0] mem_data [DEPTH];
	logic mem_first [DEPTH];
	logic mem_last [DEPTH];
	logic [2:0] mem_code [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [6:0] fill_q; // Bytes stored, 0..64.
	logic [AW-1:0] last_wr_q; // Slot of the most recent byte, tagged at packet end.
	logic [1:0] wm_sel_q; // Watermark selector.
	logic [7:0] irq_en_q; // Interrupt mask.
	logic soft_rst_q; // Soft reset control bit.
	logic soft_rst_prev_q; // Previous value, for edge detection.
	logic [5:0] sticky_q; // Latched events.
	logic [2:0] pkt_state_q; // Packet state as of last read.
	logic drop_q; // Rest of current packet is being discarded.
	logic data_prev_q; // Previous not-empty condition.
	logic wm_prev_q; // Previous above-watermark condition.
	logic first_prev_q; // Previous first-byte-at-head condition.
	logic [6:0] seg_count_q; // Bytes up to end of message at head.
	logic seg_cont_q; // Head segment does not end a message.
	logic port_ok_q; // The read in progress reported a stored byte.

	// APB decode, all on the access phase.
	// Addresses are compared in full, so aliases of a register never respond.
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic hit_irq;
	logic hit_cnt;
	logic hit_port;
	logic hit_wm;
	logic hit_live;
	logic hit_sticky;
	logic hit_ctrl;
	assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	assign wr_acc = acc && PWRITE_IN;
	assign rd_acc = acc && !PWRITE_IN;
	assign hit_irq = PADDR_IN == byte_addr(IDX_IRQ_ENABLE);
	assign hit_cnt = PADDR_IN == byte_addr(IDX_BYTES_COUNT);
	assign hit_port = PADDR_IN == byte_addr(IDX_READ_PORT);
	assign hit_wm = PADDR_IN == byte_addr(IDX_WM_CTRL);
	assign hit_live = PADDR_IN == byte_addr(IDX_LIVE_STATUS);
	assign hit_sticky = PADDR_IN == byte_addr(IDX_STICKY);
	assign hit_ctrl = PADDR_IN == byte_addr(IDX_RX_CTRL);

	// Flush pulses on the rising edge of the soft reset bit only.
	logic flush;
	assign flush = soft_rst_q && !soft_rst_prev_q;

	// FIFO conditions.
	logic fifo_full;
	logic holds_data;
	logic above_wm;
	logic pop;
	logic push;
	logic head_first;
	assign fifo_full = fill_q == 7'(DEPTH);
	assign holds_data = fill_q != 7'h00;
	assign above_wm = fill_q > wm_level(wm_sel_q);
	assign pop = rd_acc && hit_port && port_ok_q && holds_data;
	assign push = RX_BYTE_VALID_IN && !drop_q && !fifo_full && !flush;
	assign head_first = holds_data && mem_first[rd_ptr_q];

	// An arriving byte is dropped, and the packet cut, once the FIFO is full.
	logic overrun_now;
	assign overrun_now = RX_BYTE_VALID_IN && !drop_q && fifo_full;

	// Control registers written by software.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wm_sel_q <= 2'b00;
			irq_en_q <= RST_BYTE;
			soft_rst_q <= 1'b0;
		end else if (wr_acc) begin
			if (hit_wm) begin
				wm_sel_q <= PWDATA_IN[WM_SEL_LO +: 2];
			end else if (hit_irq) begin
				irq_en_q <= {2'b00, PWDATA_IN[5:0]};
			end else if (hit_ctrl) begin
				soft_rst_q <= PWDATA_IN[SOFT_RESET_BIT];
			end
		end
	end

	// Byte storage; the end mark lands on the last byte written.
	// The storage has no reset; the fill level alone says which slots hold data.
	always_ff @(posedge CLOCK_IN) begin
		if (push) begin
			mem_data[wr_ptr_q] <= RX_BYTE_DATA_IN;
			mem_first[wr_ptr_q] <= RX_OPENING_IN;
			mem_last[wr_ptr_q] <= 1'b0;
			mem_code[wr_ptr_q] <= PS_IN_PROGRESS;
		end
		if (RX_END_VALID_IN && !drop_q && fill_q != 7'h00) begin
			mem_last[last_wr_q] <= 1'b1;
			mem_code[last_wr_q] <= RX_END_CODE_IN;
		end else if (overrun_now && fill_q != 7'h00) begin
			mem_last[last_wr_q] <= 1'b1;
			mem_code[last_wr_q] <= PS_OVERRUN;
		end
	end

	// Pointers and fill level.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fill_q <= 7'h00;
			last_wr_q <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fill_q <= 7'h00;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
				last_wr_q <= wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			// A push and a pop in one cycle leave the fill level unchanged.
			fill_q <= fill_q + 7'(push) - 7'(pop);
		end
	end

	// Drop state: after overrun the rest of the packet is discarded until its end.
	// Bytes that arrive while discarding are neither stored nor counted as new overruns.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			drop_q <= 1'b0;
		end else if (flush || RX_END_VALID_IN) begin
			drop_q <= 1'b0;
		end else if (overrun_now) begin
			drop_q <= 1'b1;
		end
	end

	// Packet state as of the last FIFO read.
	// A flush returns the state to in-progress, since no byte has been read since.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pkt_state_q <= PS_IN_PROGRESS;
		end else if (flush) begin
			pkt_state_q <= PS_IN_PROGRESS;
		end else if (pop) begin
			pkt_state_q <= mem_code[rd_ptr_q];
		end
	end

	// Segment at the head: bytes up to and including the first end mark.
	always_comb begin
		logic [AW-1:0] p;
		logic found;
		found = 1'b0;
		p = '0;
		seg_count_q = fill_q;
		seg_cont_q = holds_data;
		// A linear scan over all slots costs logic depth but needs no bookkeeping on pop.
		for (int i = 0; i < DEPTH; i++) begin
			p = rd_ptr_q + AW'(i);
			if (!found && 7'(i) < fill_q && mem_last[p]) begin
				found = 1'b1;
				seg_count_q = 7'(i + 1);
				seg_cont_q = 1'b0;
			end
		end
	end

	// Edge history for event detection.
	// After reset every history bit is low, matching an empty FIFO, so no false edge follows.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			data_prev_q <= 1'b0;
			wm_prev_q <= 1'b0;
			first_prev_q <= 1'b0;
		end else begin
			data_prev_q <= holds_data;
			wm_prev_q <= above_wm;
			first_prev_q <= head_first;
		end
	end

	// Event set terms, one per latched bit.
	logic [5:0] ev_set;
	always_comb begin
		ev_set = 6'h00;
		ev_set[EV_FILLED] = holds_data && !data_prev_q;
		ev_set[EV_WM] = above_wm && !wm_prev_q;
		ev_set[EV_START] = RX_OPENING_IN && !flush;
		ev_set[EV_END] = (RX_END_VALID_IN && !drop_q) || overrun_now;
		ev_set[EV_FIRST] = head_first && !first_prev_q;
		ev_set[EV_OVF] = overrun_now;
	end

	// Latched events: cleared by read or by writing ones, a same-cycle set wins.
	logic [5:0] ev_clr;
	// A read clears only the bits that it reported; a bit that sets at the answer edge
	// was not seen by the host and must survive until the next read.
	assign ev_clr = (rd_acc && hit_sticky) ? PRDATA_OUT[5:0] :
		((wr_acc && hit_sticky) ? PWDATA_IN[5:0] : 6'h00);
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sticky_q <= 6'h00;
		end else begin
			sticky_q <= (sticky_q & ~ev_clr) | ev_set;
		end
	end

	// Interrupt: any enabled latched event drives it low.
	// It uses the next latched value, so the pin falls in the cycle after the event.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			INT_N_OUT <= 1'b1;
		end else begin
			INT_N_OUT <= !(|(((sticky_q & ~ev_clr) | ev_set) & irq_en_q[5:0]));
		end
	end

	// Deframer side outputs.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			RX_OVERRUN_OUT <= 1'b0;
			RX_SOFT_RESET_OUT <= 1'b0;
			soft_rst_prev_q <= 1'b0;
		end else begin
			RX_OVERRUN_OUT <= (drop_q || overrun_now) && !RX_END_VALID_IN && !flush;
			RX_SOFT_RESET_OUT <= flush;
			soft_rst_prev_q <= soft_rst_q;
		end
	end

	// Read mux for the first access cycle; data is registered so it stands at the access edge.
	// An unmapped address reads zero and raises the slave error.
	logic [7:0] rd_byte;
	logic mapped;
	always_comb begin
		rd_byte = RST_BYTE;
		mapped = 1'b1;
		if (hit_irq) begin
			rd_byte = irq_en_q;
		end else if (hit_cnt) begin
			rd_byte = {seg_cont_q, seg_count_q};
		end else if (hit_port) begin
			rd_byte = holds_data ? mem_data[rd_ptr_q] : RST_BYTE;
		end else if (hit_wm) begin
			rd_byte = {6'h00, wm_sel_q};
		end else if (hit_live) begin
			rd_byte = {1'b0, pkt_state_q, 2'b00, above_wm, holds_data};
		end else if (hit_sticky) begin
			rd_byte = {2'b00, sticky_q};
		end else if (hit_ctrl) begin
			rd_byte = {1'b0, soft_rst_q, 6'h00};
		end else begin
			mapped = 1'b0;
		end
	end

	// APB slave: one wait state, ready in the second access cycle.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
			PREADY_OUT <= 1'b1;
			PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			PSLVERR_OUT <= !mapped;
		end else begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end
	end

	// Remembers whether the answer edge reported a stored byte. A byte that arrives in the
	// cycle between the answer and the access edge must stay in the FIFO, since the host
	// was shown the empty-read value and not that byte.
	always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			port_ok_q <= 1'b0;
		end else begin
			port_ok_q <= PSEL_IN && PENABLE_IN && !PREADY_OUT && hit_port && holds_data;
		end
	end
endmodule

// ==== test/hdlc_rx_fifo_status_props.sv ====
// Port-level checker for the receive HDLC FIFO block.
module hdlc_rx_fifo_status_props
	import hdlc_rx_pkg::*;
#(
	parameter int DEPTH = 64 // FIFO depth in bytes.
) (
	input wire logic CLOCK_IN, // Clock.
	input wire logic ARST_N_IN, // Reset, active low.
	input wire logic PSEL_IN, // Select.
	input wire logic PENABLE_IN, // Enable.
	input wire logic PWRITE_IN, // Direction.
	input wire logic [13:0] PADDR_IN, // Address.
	input wire logic [31:0] PWDATA_IN, // Write data.
	input wire logic [31:0] PRDATA_OUT, // Read data.
	input wire logic PREADY_OUT, // Ready.
	input wire logic PSLVERR_OUT, // Error.
	input wire logic RX_BYTE_VALID_IN, // Byte strobe.
	input wire logic [7:0] RX_BYTE_DATA_IN, // Byte.
	input wire logic RX_OPENING_IN, // Opening marker.
	input wire logic RX_END_VALID_IN, // End strobe.
	input wire logic [2:0] RX_END_CODE_IN, // End code.
	input wire logic RX_OVERRUN_OUT, // Discarding.
	input wire logic RX_SOFT_RESET_OUT, // Flush pulse.
	input wire logic INT_N_OUT // Interrupt, active low.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mask_q; // Mirror of the interrupt enables.
	wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT; // Completed transfer.
	wire rd = acc && !PWRITE_IN; // Completed read.
	wire [11:0] ix = PADDR_IN[13:2]; // Register index.
	// The mirror follows bus writes so masked periods can be recognised.
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			mask_q <= 8'h00;
		end else if (acc && PWRITE_IN && ix == IDX_IRQ_ENABLE) begin
			mask_q <= PWDATA_IN[7:0];
		end
	end
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!ARST_N_IN);
	a_rdata_upper: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_ready_wait: assert property ((PSEL_IN && !PENABLE_IN) ##1 (PSEL_IN && PENABLE_IN) |-> !PREADY_OUT ##1 PREADY_OUT)
		else $error("ready not after one wait");
	a_mask_unused: assert property (rd && ix == IDX_IRQ_ENABLE |-> PRDATA_OUT[7:6] == 2'b00)
		else $error("unused enable bits set");
	a_live_unused: assert property (rd && ix == IDX_LIVE_STATUS |-> PRDATA_OUT[7] == 1'b0 && PRDATA_OUT[3:2] == 2'b00)
		else $error("unused live bits set");
	a_state_legal: assert property (rd && ix == IDX_LIVE_STATUS |-> PRDATA_OUT[6:4] <= 3'h4)
		else $error("illegal packet state");
	a_count_range: assert property (rd && ix == IDX_BYTES_COUNT |-> PRDATA_OUT[6:0] <= 7'(DEPTH))
		else $error("count above depth");
	a_flush_pulse: assert property (RX_SOFT_RESET_OUT |=> !RX_SOFT_RESET_OUT)
		else $error("flush pulse too long");
	a_masked_quiet: assert property ((mask_q == 8'h00) [*2] |-> INT_N_OUT)
		else $error("interrupt while all masked");
	a_overrun_end: assert property ($fell(RX_OVERRUN_OUT) |-> $past(RX_END_VALID_IN))
		else $error("overrun dropped without end");
	cover property (rd && ix == IDX_READ_PORT);
	cover property ($rose(RX_OVERRUN_OUT));
	cover property ($fell(INT_N_OUT));
endmodule
bind hdlc_rx_fifo_status hdlc_rx_fifo_status_props #(.DEPTH(DEPTH)) u_props (.CLOCK_IN(CLOCK_IN),
	.ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
	.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .RX_BYTE_VALID_IN(RX_BYTE_VALID_IN), .RX_BYTE_DATA_IN(RX_BYTE_DATA_IN),
	.RX_OPENING_IN(RX_OPENING_IN), .RX_END_VALID_IN(RX_END_VALID_IN), .RX_END_CODE_IN(RX_END_CODE_IN),
	.RX_OVERRUN_OUT(RX_OVERRUN_OUT), .RX_SOFT_RESET_OUT(RX_SOFT_RESET_OUT), .INT_N_OUT(INT_N_OUT));

// ==== test/hdlc_deframer_model.sv ====
// Behavioural deframer that feeds bytes and packet ends into the block.
module hdlc_deframer_model (
	input wire logic clk_in, // Clock.
	output logic valid_out, // Byte strobe.
	output logic [7:0] data_out, // Byte.
	output logic opening_out, // Opening marker.
	output logic end_out, // End strobe.
	output logic [2:0] code_out // End code.
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle lines start low.
	initial begin
		valid_out = 1'b0;
		data_out = 8'h00;
		opening_out = 1'b0;
		end_out = 1'b0;
		code_out = 3'h0;
	end
	// One byte; data shows the inverse afterwards so stale values are never mistaken for fresh ones.
	task automatic push(input logic [7:0] b, input logic first);
		@(posedge clk_in);
		valid_out <= 1'b1;
		data_out <= b;
		opening_out <= first;
		@(posedge clk_in);
		valid_out <= 1'b0;
		opening_out <= 1'b0;
		data_out <= ~b;
	endtask
	// Packet end, always at least one cycle after the last byte.
	task automatic finish(input logic [2:0] c);
		@(posedge clk_in);
		end_out <= 1'b1;
		code_out <= c;
		@(posedge clk_in);
		end_out <= 1'b0;
		code_out <= ~c;
	endtask
endmodule

// ==== test/hdlc_rx_fifo_status_tb.sv ====
// Self-checking bench for the receive HDLC FIFO block.
module hdlc_rx_fifo_status_tb;
	import hdlc_rx_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, ovr, srst, int_n, rxv, rxo, rxe;
	logic [7:0] rxd;
	logic [2:0] rxc;
	int mismatches = 0;
	int checks_done = 0;
	int pulses = 0;
	always #12.5 clk = ~clk;
	// Flush pulses are counted as they pass.
	always @(posedge clk) begin
		if (srst === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	hdlc_rx_fifo_status uut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .RX_BYTE_VALID_IN(rxv), .RX_BYTE_DATA_IN(rxd), .RX_OPENING_IN(rxo),
		.RX_END_VALID_IN(rxe), .RX_END_CODE_IN(rxc), .RX_OVERRUN_OUT(ovr), .RX_SOFT_RESET_OUT(srst), .INT_N_OUT(int_n));
	hdlc_deframer_model dfm (.clk_in(clk), .valid_out(rxv), .data_out(rxd), .opening_out(rxo), .end_out(rxe),
		.code_out(rxc));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus transfer; the request stands until ready is sampled high.
	task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] ix, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, ix, d, r, e);
	endtask
	// Only index zero among those used here is unmapped.
	task automatic rd(input string what, input logic [11:0] ix, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, ix, 8'h00, r, e);
		check(what, r, {24'h00_0000, x});
		check("slverr", {31'h0, e}, {31'h0, ix == 12'h000});
	endtask
	initial begin
		int i;
		int c;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd("enable", IDX_IRQ_ENABLE, 8'h00);
		rd("count", IDX_BYTES_COUNT, 8'h00);
		rd("data", IDX_READ_PORT, 8'h00);
		rd("wmark", IDX_WM_CTRL, 8'h00);
		rd("live", IDX_LIVE_STATUS, 8'h00);
		rd("sticky", IDX_STICKY, 8'h00);
		rd("unmapped", 12'h000, 8'h00);
		wr(IDX_IRQ_ENABLE, 8'hFF);
		rd("enable", IDX_IRQ_ENABLE, 8'h3F);
		check("int", {31'h0, int_n}, 32'h0000_0001);
		$display("register test done");
		dfm.push(8'hA5, 1'b1);
		dfm.push(8'h3C, 1'b0);
		dfm.finish(PS_GOOD);
		repeat (3) @(posedge clk);
		check("int", {31'h0, int_n}, 32'h0000_0000);
		rd("count", IDX_BYTES_COUNT, 8'h02);
		rd("live", IDX_LIVE_STATUS, 8'h01);
		rd("sticky", IDX_STICKY, 8'h1D);
		repeat (3) @(posedge clk);
		check("int", {31'h0, int_n}, 32'h0000_0001);
		rd("sticky", IDX_STICKY, 8'h00);
		rd("data", IDX_READ_PORT, 8'hA5);
		rd("live", IDX_LIVE_STATUS, 8'h01);
		rd("data", IDX_READ_PORT, 8'h3C);
		rd("live", IDX_LIVE_STATUS, 8'h10);
		rd("data", IDX_READ_PORT, 8'h00);
		$display("packet test done");
		wr(IDX_IRQ_ENABLE, 8'h00);
		for (i = 0; i < 48; i++) begin
			dfm.push(8'(i * 37 + 5), i == 0);
		end
		// Upper selector bits are always written as zero.
		for (c = 0; c < 4; c++) begin
			wr(IDX_WM_CTRL, 8'(c));
			rd("live", IDX_LIVE_STATUS, (c < 3) ? 8'h13 : 8'h11);
		end
		dfm.push(8'(48 * 37 + 5), 1'b0);
		rd("live", IDX_LIVE_STATUS, 8'h13);
		wr(IDX_STICKY, 8'h01);
		rd("sticky", IDX_STICKY, 8'h16);
		rd("live", IDX_LIVE_STATUS, 8'h13);
		rd("count", IDX_BYTES_COUNT, 8'hB1);
		for (i = 49; i < 65; i++) begin
			dfm.push(8'(i * 37 + 5), 1'b0);
		end
		repeat (2) @(posedge clk);
		check("overrun", {31'h0, ovr}, 32'h0000_0001);
		dfm.finish(PS_GOOD);
		repeat (2) @(posedge clk);
		check("overrun", {31'h0, ovr}, 32'h0000_0000);
		rd("sticky", IDX_STICKY, 8'h28);
		rd("count", IDX_BYTES_COUNT, 8'h40);
		for (i = 0; i < 64; i++) begin
			rd("data", IDX_READ_PORT, 8'(i * 37 + 5));
		end
		rd("live", IDX_LIVE_STATUS, 8'h40);
		$display("fill test done");
		for (c = 1; c < 4; c++) begin
			dfm.push(8'h5A, 1'b1);
			dfm.finish(3'(c));
			rd("data", IDX_READ_PORT, 8'h5A);
			rd("live", IDX_LIVE_STATUS, 8'(c << 4));
		end
		$display("code test done");
		dfm.push(8'h11, 1'b1);
		dfm.push(8'h22, 1'b0);
		wr(IDX_RX_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		rd("count", IDX_BYTES_COUNT, 8'h00);
		rd("data", IDX_READ_PORT, 8'h00);
		check("flush", 32'(pulses), 32'h0000_0001);
		wr(IDX_RX_CTRL, 8'h00);
		wr(IDX_RX_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		check("flush", 32'(pulses), 32'h0000_0002);
		$display("flush test done");
		final_report();
	end
endmodule
